// ===== verilog/pid_loop_regs.vh
/*
 loop table and control register map for the pid loop evaluator.
 assumes: apb byte addresses, 32-bit words, reals as signed q16.16.
*/
`ifndef PID_LOOP_REGS_VH
`define PID_LOOP_REGS_VH

// loop table, byte offsets
`define TABLE_BYTES 8'h50
`define OFS_PROCESS_VALUE 8'h00
`define OFS_TARGET_VALUE 8'h04
`define OFS_CONTROL_OUTPUT 8'h08
`define OFS_LOOP_GAIN 8'h0C
`define OFS_SAMPLE_PERIOD 8'h10
`define OFS_RESET_INTERVAL 8'h14
`define OFS_RATE_INTERVAL 8'h18
`define OFS_BIAS_SUM 8'h1C
`define OFS_PRIOR_PROCESS_VALUE 8'h20
`define OFS_AUTOTUNE_SCRATCH 8'h24

// control and status words
`define OFS_CTRL 8'h50
`define OFS_SCAN 8'h54
`define OFS_STATUS 8'h58

// field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_RUN_BIT 1
`define STAT_FAULT_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_AUTO_BIT 2
`define STAT_HIST_BIT 3

// reset values
`define CTRL_RESET 2'h0
`define TABLE_RESET 32'h0000_0000

// number format and timing
`define Q_ONE 32'h0001_0000
`define SEC_PER_MIN 40'h00_0000_003C
`define DIV_STEPS 7'h40

`endif

// ===== verilog/pid_loop_mode_table.v
/*
 pid loop evaluator with an 80-byte loop table behind an apb slave.
 assumes: software drives enable/run and starts each scan by a write.
*/
// The APB interface to the registers is this design's own decision.
//
// Function
// - evaluate the loop only on scans where the enable input is true.
// - keep a one-bit enable history and detect its rising change.
// - on rising change copy process value and output for bumpless start.
// - history bit is set at reset and on each stop-to-run change.
// - enable already true at first run scan gives no bumpless actions.
// - arithmetic fault sets the math fault flag and aborts evaluation.
// - the loop table is 80 bytes with fields at fixed offsets.
// - process value at offset 0 is read only.
// - target value at offset 4 is read, and loaded with process value on bumpless start.
// - control output at offset 8 is input and result.
// - signed gain at offset 12 selects forward or reverse action.
// - sample period in seconds at offset 16, positive.
// - integral time in minutes at offset 20, positive.
// - derivative time in minutes at offset 24, zero or positive.
// - bias sum at offset 28 is read and updated.
// - store current process value at offset 32 as prior value.
// - write output limited to 0..1 at end of evaluation.
// - on output overrange, reset bias from proportional plus derivative.
// - limit updated bias to 0..1 and store it.
`timescale 1ns/10ps
`include "pid_loop_regs.vh"

module pid_loop_mode_table (
  input wire i_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  output wire o_math_fault,
  output wire o_busy
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DIV = 3'h1;
  localparam [2:0] S_CALC1 = 3'h2;
  localparam [2:0] S_CALC2 = 3'h3;
  localparam [2:0] S_CALC3 = 3'h4;

  ////////////////////////////////////////////////////////////////////
  // helpers

  function [4:0] widx;
    input [7:0] a;
    begin
      widx = a[6:2];
    end
  endfunction

  function [63:0] sx;
    input [31:0] v;
    begin
      sx = {{32{v[31]}}, v};
    end
  endfunction

  function [63:0] mulq;
    input [31:0] a;
    input [31:0] b;
    reg signed [63:0] p;
    begin
      p = $signed(a) * $signed(b);
      mulq = {{16{p[63]}}, p[63:16]};
    end
  endfunction

  function fits;
    input [63:0] v;
    begin
      fits = (&v[63:31]) | (~|v[63:31]);
    end
  endfunction

  function [31:0] clampq;
    input [63:0] v;
    begin
      if (v[63])
        clampq = 32'h0000_0000;
      else if ($signed(v) > $signed(sx(`Q_ONE)))
        clampq = `Q_ONE;
      else
        clampq = v[31:0];
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          wmerge[8*k +: 8] = nw[8*k +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  reg [31:0] tbl_q [0:19];
  reg [1:0] ctrl_q;
  reg hist_q;
  reg auto_q;
  reg fault_q;
  reg [2:0] state_q;
  reg dsel_q;
  reg [6:0] cnt_q;
  reg [63:0] dvd_q;
  reg [40:0] rem_q;
  reg [39:0] dvs_q;
  reg [63:0] quo_q;
  reg [31:0] ki_q;
  reg [31:0] kd_q;
  reg [63:0] err_q;
  reg [63:0] dpv_q;
  reg [63:0] gki_q;
  reg [63:0] gkd_q;
  reg [63:0] mp_q;
  reg [63:0] mi_q;
  reg [63:0] md_q;

  wire [31:0] proc_v = tbl_q[widx(`OFS_PROCESS_VALUE)];
  wire [31:0] targ_v = tbl_q[widx(`OFS_TARGET_VALUE)];
  wire [31:0] outp_v = tbl_q[widx(`OFS_CONTROL_OUTPUT)];
  wire [31:0] gain_v = tbl_q[widx(`OFS_LOOP_GAIN)];
  wire [31:0] per_v = tbl_q[widx(`OFS_SAMPLE_PERIOD)];
  wire [31:0] irst_v = tbl_q[widx(`OFS_RESET_INTERVAL)];
  wire [31:0] drat_v = tbl_q[widx(`OFS_RATE_INTERVAL)];
  wire [31:0] bias_v = tbl_q[widx(`OFS_BIAS_SUM)];
  wire [31:0] prior_v = tbl_q[widx(`OFS_PRIOR_PROCESS_VALUE)];
  wire enable = ctrl_q[`CTRL_ENABLE_BIT];
  wire run = ctrl_q[`CTRL_RUN_BIT];

  ////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable;
  wire in_tbl = (i_paddr < `TABLE_BYTES);
  wire addr_ok = (i_paddr[1:0] == 2'h0) & (in_tbl | (i_paddr == `OFS_CTRL)
    | (i_paddr == `OFS_SCAN) | (i_paddr == `OFS_STATUS));
  wire wr = access & i_pwrite & addr_ok;
  wire wr_tbl = wr & in_tbl;
  wire wr_ctrl = wr & (i_paddr == `OFS_CTRL);
  wire wr_stat = wr & (i_paddr == `OFS_STATUS);
  wire [31:0] ctrl_new = wmerge({30'h0, ctrl_q}, i_pwdata, i_pstrb);
  wire scan_go = wr & (i_paddr == `OFS_SCAN) & run & (state_q == S_IDLE);
  wire fault_clr = wr_stat & i_pstrb[0] & i_pwdata[`STAT_FAULT_BIT];

  assign o_pready = 1'b1;
  assign o_pslverr = access & ~addr_ok;
  assign o_math_fault = fault_q;
  assign o_busy = (state_q != S_IDLE);

  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (addr_ok & in_tbl)
      rd_mux = tbl_q[widx(i_paddr)];
    else if (addr_ok & (i_paddr == `OFS_CTRL))
      rd_mux = {30'h0, ctrl_q};
    else if (addr_ok & (i_paddr == `OFS_STATUS))
      rd_mux = {28'h0, hist_q, auto_q, o_busy, fault_q};
  end

  // read data captured in the setup cycle
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_prdata <= 32'h0000_0000;
    else if (setup)
      o_prdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////
  // datapath

  reg [40:0] rem_n;
  reg [63:0] err_n;
  reg [63:0] dpv_n;
  reg [63:0] gki_n;
  reg [63:0] gkd_n;
  reg [63:0] mp_n;
  reg [63:0] mi_n;
  reg [63:0] md_n;
  reg [63:0] isum;
  reg [63:0] msum;
  reg [63:0] pdsum;
  reg [63:0] bias_n;
  reg parm_bad;
  reg fault_set;
  reg bump_we;
  reg fin_we;

  always @*
  begin
    rem_n = {rem_q[39:0], dvd_q[63]};
    err_n = sx(targ_v) - sx(proc_v);
    dpv_n = sx(prior_v) - sx(proc_v);
    gki_n = mulq(gain_v, ki_q);
    gkd_n = mulq(gain_v, kd_q);
    mp_n = mulq(gain_v, err_q[31:0]);
    mi_n = mulq(gki_q[31:0], err_q[31:0]);
    md_n = mulq(gkd_q[31:0], dpv_q[31:0]);
    // output is p plus integral sum plus d
    isum = sx(bias_v) + mi_q;
    pdsum = mp_q + md_q;
    msum = isum + pdsum;
    if ($signed(msum) > $signed(sx(`Q_ONE)))
      bias_n = sx(`Q_ONE) - pdsum;
    else if (msum[63])
      bias_n = 64'h0000_0000_0000_0000 - pdsum;
    else
      bias_n = isum;
    parm_bad = per_v[31] | (~|per_v) | irst_v[31] | (~|irst_v) | drat_v[31];
    fault_set = 1'b0;
    if (scan_go & enable & parm_bad)
      fault_set = 1'b1;
    if ((state_q == S_DIV) & (cnt_q == 7'h00) & (|quo_q[63:31]))
      fault_set = 1'b1;
    if ((state_q == S_CALC1) & ~(fits(err_n) & fits(dpv_n) & fits(gki_n) & fits(gkd_n)))
      fault_set = 1'b1;
    if ((state_q == S_CALC2) & ~(fits(mp_n) & fits(mi_n) & fits(md_n)))
      fault_set = 1'b1;
    bump_we = scan_go & enable & ~hist_q;
    fin_we = (state_q == S_CALC3);
  end

  ////////////////////////////////////////////////////////////////////
  // loop table

  integer i;
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (i = 0; i < 20; i = i + 1)
        tbl_q[i] <= `TABLE_RESET;
    end
    else
    begin
      if (wr_tbl)
        tbl_q[widx(i_paddr)] <= wmerge(tbl_q[widx(i_paddr)], i_pwdata, i_pstrb);
      if (bump_we)
      begin
        tbl_q[widx(`OFS_TARGET_VALUE)] <= proc_v;
        tbl_q[widx(`OFS_PRIOR_PROCESS_VALUE)] <= proc_v;
        tbl_q[widx(`OFS_BIAS_SUM)] <= outp_v;
      end
      // only offsets 8, 28 and 32 written back
      if (fin_we)
      begin
        tbl_q[widx(`OFS_CONTROL_OUTPUT)] <= clampq(msum);
        tbl_q[widx(`OFS_BIAS_SUM)] <= clampq(bias_n);
        tbl_q[widx(`OFS_PRIOR_PROCESS_VALUE)] <= proc_v;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control and flags

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_q <= `CTRL_RESET;
      hist_q <= 1'b1;
      auto_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_new[1:0];
      // history set on stop to run
      if (wr_ctrl & ctrl_new[`CTRL_RUN_BIT] & ~run)
        hist_q <= 1'b1;
      else if (scan_go)
        hist_q <= enable;
      if (scan_go)
        auto_q <= enable;
      fault_q <= (fault_q & ~fault_clr) | fault_set;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // evaluation sequencer

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= S_IDLE;
      dsel_q <= 1'b0;
      cnt_q <= 7'h00;
      dvd_q <= 64'h0000_0000_0000_0000;
      rem_q <= 41'h000_0000_0000;
      dvs_q <= 40'h00_0000_0000;
      quo_q <= 64'h0000_0000_0000_0000;
      ki_q <= 32'h0000_0000;
      kd_q <= 32'h0000_0000;
      err_q <= 64'h0000_0000_0000_0000;
      dpv_q <= 64'h0000_0000_0000_0000;
      gki_q <= 64'h0000_0000_0000_0000;
      gkd_q <= 64'h0000_0000_0000_0000;
      mp_q <= 64'h0000_0000_0000_0000;
      mi_q <= 64'h0000_0000_0000_0000;
      md_q <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (scan_go & enable & ~parm_bad)
          begin
            // ki = period / (60 * integral time)
            dvd_q <= {16'h0000, per_v, 16'h0000};
            dvs_q <= {8'h00, irst_v} * `SEC_PER_MIN;
            rem_q <= 41'h000_0000_0000;
            quo_q <= 64'h0000_0000_0000_0000;
            cnt_q <= `DIV_STEPS;
            dsel_q <= 1'b0;
            state_q <= S_DIV;
          end
        end
        S_DIV:
        begin
          if (cnt_q == 7'h00)
          begin
            if (fault_set)
              state_q <= S_IDLE;
            else if (~dsel_q)
            begin
              ki_q <= quo_q[31:0];
              // kd = 60 * derivative time / period
              dvd_q <= {8'h00, {8'h00, drat_v} * `SEC_PER_MIN, 16'h0000};
              dvs_q <= {8'h00, per_v};
              rem_q <= 41'h000_0000_0000;
              quo_q <= 64'h0000_0000_0000_0000;
              cnt_q <= `DIV_STEPS;
              dsel_q <= 1'b1;
            end
            else
            begin
              kd_q <= quo_q[31:0];
              state_q <= S_CALC1;
            end
          end
          else
          begin
            dvd_q <= {dvd_q[62:0], 1'b0};
            cnt_q <= cnt_q - 7'h01;
            if (rem_n >= {1'b0, dvs_q})
            begin
              rem_q <= rem_n - {1'b0, dvs_q};
              quo_q <= {quo_q[62:0], 1'b1};
            end
            else
            begin
              rem_q <= rem_n;
              quo_q <= {quo_q[62:0], 1'b0};
            end
          end
        end
        S_CALC1:
        begin
          err_q <= err_n;
          dpv_q <= dpv_n;
          // signed gain folds into both rates
          gki_q <= gki_n;
          gkd_q <= gkd_n;
          state_q <= fault_set ? S_IDLE : S_CALC2;
        end
        S_CALC2:
        begin
          mp_q <= mp_n;
          mi_q <= mi_n;
          md_q <= md_n;
          state_q <= fault_set ? S_IDLE : S_CALC3;
        end
        S_CALC3:
          state_q <= S_IDLE;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

endmodule

// ===== sim/loop_program.sv
/*
 apb master model of the program that runs the loop.
 assumes: one clock, slave gives pready.
*/
`timescale 1ns/10ps
module loop_program (
  input wire i_clk,
  input wire [31:0] i_prdata,
  input wire i_pready,
  input wire i_pslverr,
  output reg o_psel,
  output reg o_penable,
  output reg o_pwrite,
  output reg [7:0] o_paddr,
  output reg [31:0] o_pwdata,
  output reg [3:0] o_pstrb
);
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
    o_pstrb = 4'hf;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (!i_pready)
      @(posedge i_clk);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata <= ~d;
  endtask
endmodule

// ===== sim/pid_loop_mode_table_chk.sv
/*
 port checker for the pid loop evaluator.
 assumes: bound to pid_loop_mode_table, ctrl enable/run in byte 0.
*/
`timescale 1ns/10ps
`include "pid_loop_regs.vh"
module pid_loop_chk (
  input wire i_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_math_fault,
  input wire o_busy
);
  reg en_q;
  reg run_q;
  reg [7:0] cnt_q;
  wire acc = i_psel && i_penable;
  wire wr = acc && i_pwrite;
  wire scan = wr && i_paddr == `OFS_SCAN;
  wire go = scan && run_q && en_q;
  wire bad = i_paddr[1:0] != 2'b00 || i_paddr > `OFS_STATUS;
  always @(posedge i_clk or posedge i_rst)
    if (i_rst)
    begin
      en_q <= 1'b0;
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end
    else
    begin
      if (wr && i_paddr == `OFS_CTRL && i_pstrb[0])
      begin
        en_q <= i_pwdata[0];
        run_q <= i_pwdata[1];
      end
      cnt_q <= o_busy ? cnt_q + 8'h01 : 8'h00;
    end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_quiet;
    !o_busy [*2];
  endsequence
  a_err_unmapped: assert property (acc |-> o_pslverr == bad) else $error("pslverr wrong");
  a_ready_high: assert property (acc |-> o_pready) else $error("pready low");
  a_manual_idle: assert property (scan && run_q && !en_q && !o_busy |=> s_quiet)
    else $error("manual scan ran");
  a_busy_cause: assert property ($rose(o_busy) |-> $past(go) || $past(go, 2))
    else $error("busy without scan");
  a_busy_len: assert property ($fell(o_busy) && !o_math_fault |-> cnt_q == 8'h85)
    else $error("evaluation length");
  a_fault_cause: assert property ($rose(o_math_fault) |-> $past(scan) || $past(o_busy))
    else $error("fault without scan");
  a_fault_abort: assert property ($rose(o_math_fault) |=> !o_busy)
    else $error("fault did not abort");
  a_fault_clear: assert property (wr && i_paddr == `OFS_STATUS && i_pwdata[0] && !o_busy
    |=> !o_math_fault) else $error("fault not cleared");
endmodule
bind pid_loop_mode_table pid_loop_chk chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_math_fault(o_math_fault), .o_busy(o_busy));

// ===== sim/tb_pid_loop_mode_table.sv
/*
 testbench for the pid loop evaluator, one task per scenario.
 assumes: loop_program as apb master, reals in q16.16.
*/
`timescale 1ns/10ps
`include "pid_loop_regs.vh"
module tb_pid_loop_mode_table;
  reg i_clk;
  reg i_rst;
  wire psel, penable, pwrite, pready, pslverr, fault, busy;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] pstrb;
  integer mismatches = 0;
  integer checks_done = 0;
  logic [31:0] q;
  logic e;
  pid_loop_mode_table dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_math_fault(fault), .o_busy(busy));
  loop_program prog (.i_clk(i_clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .o_pstrb(pstrb));
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task results;
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checks_done++;
    if (s !== x)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    prog.xfer(1'b1, a, d, q, e);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] x, input string n);
    prog.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(n, x, q);
  endtask
  task scan;
    wr(`OFS_SCAN, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    while (busy === 1'b1)
      @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    logic [7:0] a;
    for (a = 8'h00; a < `TABLE_BYTES; a = a + 8'h04)
      rc(a, 32'h0000_0000, "table");
    rc(`OFS_STATUS, 32'h0000_0008, "status");
  endtask
  task t_map;
    wr(8'h4C, 32'h1234_5678);
    rc(8'h4C, 32'h1234_5678, "scratch");
    prog.xfer(1'b0, 8'h5C, 32'h0000_0000, q, e);
    chk("unmapped", 32'h0000_0001, {31'h0, e});
  endtask
  task t_manual;
    wr(`OFS_CTRL, 32'h0000_0002);
    wr(`OFS_CONTROL_OUTPUT, 32'h0000_4000);
    scan;
    rc(`OFS_STATUS, 32'h0000_0000, "status");
    rc(`OFS_BIAS_SUM, 32'h0000_0000, "bias");
  endtask
  task t_bumpless;
    wr(`OFS_PROCESS_VALUE, 32'h0000_8000);
    wr(`OFS_TARGET_VALUE, 32'h0000_3333);
    wr(`OFS_SAMPLE_PERIOD, 32'h0001_0000);
    wr(`OFS_RESET_INTERVAL, 32'h0001_0000);
    wr(`OFS_CTRL, 32'h0000_0003);
    scan;
    rc(`OFS_TARGET_VALUE, 32'h0000_8000, "target");
    rc(`OFS_PRIOR_PROCESS_VALUE, 32'h0000_8000, "prior");
    rc(`OFS_BIAS_SUM, 32'h0000_4000, "bias");
    rc(`OFS_CONTROL_OUTPUT, 32'h0000_4000, "output");
    rc(`OFS_STATUS, 32'h0000_000C, "status");
  endtask
  task t_clamp;
    wr(`OFS_TARGET_VALUE, 32'h0000_C000);
    wr(`OFS_LOOP_GAIN, 32'h0004_0000);
    scan;
    rc(`OFS_CONTROL_OUTPUT, 32'h0001_0000, "output");
    rc(`OFS_BIAS_SUM, 32'h0000_0000, "bias");
    rc(`OFS_TARGET_VALUE, 32'h0000_C000, "target");
    wr(`OFS_LOOP_GAIN, 32'hFFFC_0000);
    scan;
    rc(`OFS_CONTROL_OUTPUT, 32'h0000_0000, "output");
    rc(`OFS_BIAS_SUM, 32'h0001_0000, "bias");
    rc(`OFS_PROCESS_VALUE, 32'h0000_8000, "process");
  endtask
  task t_fault;
    wr(`OFS_SAMPLE_PERIOD, 32'h0000_0000);
    scan;
    chk("fault", 32'h0000_0001, {31'h0, fault});
    rc(`OFS_STATUS, 32'h0000_000D, "status");
    rc(`OFS_CONTROL_OUTPUT, 32'h0000_0000, "output");
    wr(`OFS_STATUS, 32'h0000_0001);
    @(negedge i_clk);
    chk("fault", 32'h0000_0000, {31'h0, fault});
    wr(`OFS_SAMPLE_PERIOD, 32'h0001_0000);
    // derivative rate overflows the second divide
    wr(`OFS_RATE_INTERVAL, 32'h7FFF_0000);
    scan;
    chk("fault", 32'h0000_0001, {31'h0, fault});
    rc(`OFS_BIAS_SUM, 32'h0001_0000, "bias");
    wr(`OFS_STATUS, 32'h0000_0001);
    wr(`OFS_RATE_INTERVAL, 32'h0000_0000);
  endtask
  task t_restart;
    // manual scan clears history before the stop
    wr(`OFS_CTRL, 32'h0000_0002);
    scan;
    wr(`OFS_CTRL, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0003);
    rc(`OFS_STATUS, 32'h0000_0008, "status");
    wr(`OFS_PROCESS_VALUE, 32'h0000_6000);
    wr(`OFS_LOOP_GAIN, 32'h0000_0000);
    scan;
    rc(`OFS_TARGET_VALUE, 32'h0000_C000, "target");
    rc(`OFS_PRIOR_PROCESS_VALUE, 32'h0000_6000, "prior");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    i_rst = 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_map;
    t_manual;
    t_bumpless;
    t_clamp;
    t_fault;
    t_restart;
    results;
  end
  initial
  begin
    #100000;
    mismatches++;
    results;
  end
endmodule
